// >>> pkg/physc_consts.svh
// Offsets, field positions, reset values and timing counts of the status and power-save block.
// Assumes a 200 MHz clock and a byte-addressed 32-bit Avalon-MM register port.
`ifndef PHYSC_CONSTS_SVH
`define PHYSC_CONSTS_SVH

// ------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------
`define PHYSC_IDX_BSR      8'h01
`define PHYSC_IDX_AUTONEG_EXPANSION_REG     8'h06
`define PHYSC_IDX_STS      8'h10
`define PHYSC_IDX_CTL      8'h11
`define PHYSC_IDX_ISR      8'h12
`define PHYSC_IDX_FCC      8'h14
`define PHYSC_IDX_EVT      8'h20
`define PHYSC_IDX_MASK     8'h21

// ------------------------------------------------------------
// Control word fields and reset value
// ------------------------------------------------------------
`define PHYSC_CTL_PLL_OFF  15
`define PHYSC_CTL_PS_EN    14
`define PHYSC_CTL_MODE_HI  13
`define PHYSC_CTL_MODE_LO  12
`define PHYSC_CTL_SCR_BYP  11
`define PHYSC_CTL_RESET    16'h0000
`define PHYSC_CTL_WMASK    16'hf800

// ------------------------------------------------------------
// Status word field positions
// ------------------------------------------------------------
`define PHYSC_ST_FCS       11
`define PHYSC_ST_SD        10
`define PHYSC_ST_DL        9
`define PHYSC_ST_PR        8
`define PHYSC_ST_INT       7
`define PHYSC_ST_RF        6
`define PHYSC_ST_JAB       5
`define PHYSC_ST_AN        4
`define PHYSC_ST_LB        3
`define PHYSC_ST_DUP       2
`define PHYSC_ST_SPD       1
`define PHYSC_ST_LNK       0

// ------------------------------------------------------------
// Event bits and timing
// ------------------------------------------------------------
`define PHYSC_EV_WAKE      0
`define PHYSC_EV_NLP       1
`define PHYSC_EV_FCS       2
`define PHYSC_NLP_PERIOD_MS 1400
`define PHYSC_CLK_MHZ      200
`define PHYSC_NLP_CYCLES   (`PHYSC_NLP_PERIOD_MS * 1000 * `PHYSC_CLK_MHZ)

`endif

// >>> pkg/physc_pkg.sv
// Types shared by the status and power-save block.
// Assumes physc_consts.svh for numeric constants.
package physc_pkg;

   // Power mode field encodings
   typedef enum logic [1:0] {
      physc_mode_normal   = 2'b00,
      physc_mode_reserved = 2'b01,
      physc_mode_active   = 2'b10,
      physc_mode_passive  = 2'b11
   } physc_mode_e;

   // Sleep sequencer states, Gray coded along awake -> asleep -> waking
   typedef enum logic [1:0] {
      physc_st_awake  = 2'b00,
      physc_st_asleep = 2'b01,
      physc_st_waking = 2'b11
   } physc_sleep_e;

   // Live indications from the transceiver core
   typedef struct packed {
      logic false_carrier;
      logic signal_detect;
      logic descr_lock;
      logic page_rx_event;
      logic int_pending_event;
      logic remote_fault_event;
      logic jabber;
      logic an_done;
      logic loopback;
      logic full_duplex;
      logic speed_10;
      logic link_up;
      logic energy_detect;
      logic std_power_down;
   } physc_core_s;

   // Control outputs toward the transceiver core
   typedef struct packed {
      logic pll_disable;
      logic scr_bypass;
      logic sleep;
      logic nlp_pulse;
   } physc_ctl_s;

   // Avalon-MM slave request
   typedef struct packed {
      logic [7:0]  address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } physc_avm_req_s;

   // Avalon-MM slave answer
   typedef struct packed {
      logic [31:0] readdata;
      logic        waitrequest;
      logic [1:0]  response;
   } physc_avm_rsp_s;

endpackage

// >>> hdl/physc_top.sv
// Status word and power-save control word of a 10/100 transceiver, on Avalon-MM.
// Assumes core indications are synchronous to clk except signal_detect and descr_lock,
// which are synchronised here; the host ignores those two bits during low power idle.
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "physc_consts.svh"

module physc_top
   import physc_pkg::*;
#(
   parameter int unsigned NLP_CYCLES = `PHYSC_NLP_CYCLES
)(
   // Clock and reset
   input  wire logic                     clk,
   input  wire logic                     reset,
   // Register port
   input  wire physc_pkg::physc_avm_req_s avm_req,
   output      physc_pkg::physc_avm_rsp_s avm_rsp,
   // Transceiver core
   input  wire physc_pkg::physc_core_s   core,
   output      physc_pkg::physc_ctl_s    ctl,
   // Interrupt
   output      logic                     irq
);
   import physc_pkg::*;

   // Elaboration check: the pulse counter needs a period of at least two cycles,
   // otherwise the terminal count and the restart would fall on the same edge
   if (NLP_CYCLES < 2) begin : g_nlp_period_check
      $error("NLP_CYCLES must be at least 2");
   end

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [31:0]  nlp_cnt;
      physc_sleep_e sleep_st;
      logic         fcs;
      logic         sd;
      logic         dl;
      logic         pr;
      logic         intp;
      logic         rf;
      logic [15:0]  ctl_w;
      logic [2:0]   evt;
      logic [2:0]   mask;
      logic         ack;
      logic [31:0]  rdata;
      logic [1:0]   resp;
      physc_ctl_s   ctl_o;
      logic         irq_o;
      logic         wait_req;
      logic [1:0]   sync_a;
      logic [1:0]   sync_b;
   } physc_state_s;

   physc_state_s st;
   physc_state_s next_st;

   // Two-stage synchronisers for the asynchronous PMD indications. The stages sit in
   // the state struct; a loss shorter than one clock period may be missed, which is
   // acceptable for a slow management view of the receive path
   wire sd_live = st.sync_b[1];
   wire dl_live = st.sync_b[0];

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   wire       acc     = (avm_req.read | avm_req.write) & ~st.ack;
   wire       rd_acc  = acc & avm_req.read;
   wire       wr_acc  = acc & avm_req.write;
   wire [7:0] idx     = avm_req.address >> 2;
   wire       aligned = (avm_req.address[1:0] == 2'h0);

   logic [15:0] sts_word;
   physc_mode_e mode;

   // Status word assembly. Live bits are copied straight from the core; the read
   // data flop samples them at the take edge, so a change in that same cycle
   // only shows on the following read
   always_comb begin
      sts_word = 16'h0000;
      sts_word[`PHYSC_ST_FCS] = st.fcs;
      sts_word[`PHYSC_ST_SD]  = st.sd;
      sts_word[`PHYSC_ST_DL]  = st.dl;
      sts_word[`PHYSC_ST_PR]  = st.pr;
      sts_word[`PHYSC_ST_INT] = st.intp;
      sts_word[`PHYSC_ST_RF]  = st.rf;
      sts_word[`PHYSC_ST_JAB] = core.jabber;
      sts_word[`PHYSC_ST_AN]  = core.an_done;
      sts_word[`PHYSC_ST_LB]  = core.loopback;
      sts_word[`PHYSC_ST_DUP] = core.full_duplex;
      sts_word[`PHYSC_ST_SPD] = core.speed_10;
      sts_word[`PHYSC_ST_LNK] = core.link_up;
   end

   assign mode = physc_mode_e'(st.ctl_w[`PHYSC_CTL_MODE_HI:`PHYSC_CTL_MODE_LO]);

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      logic        rd_sts;
      logic        sleep_req;
      logic [2:0]  ev_set;
      next_st   = st;
      rd_sts    = rd_acc & aligned & (idx == `PHYSC_IDX_STS);
      ev_set    = 3'h0;
      sleep_req = st.ctl_w[`PHYSC_CTL_PS_EN] &&
                  (mode == physc_mode_active || mode == physc_mode_passive);

      // Synchroniser stages; nothing but the second stage is read
      next_st.sync_a = {core.signal_detect, core.descr_lock};
      next_st.sync_b = st.sync_a;

      // Bus answer: one wait state, then the access completes. Waitrequest has a
      // flop of its own so the port carries no logic; it idles high, which also
      // holds off a request in the cycle before the decode has seen it
      next_st.ack      = acc;
      next_st.wait_req = ~acc;
      next_st.resp     = 2'h0;
      next_st.rdata    = 32'h0;
      if (rd_acc) begin
         if (!aligned) begin
            next_st.resp = 2'h2;
         end else begin
            unique case (idx)
               `PHYSC_IDX_STS:  next_st.rdata = {16'h0, sts_word};
               `PHYSC_IDX_CTL:  next_st.rdata = {16'h0, st.ctl_w};
               `PHYSC_IDX_EVT:  next_st.rdata = {29'h0, st.evt};
               `PHYSC_IDX_MASK: next_st.rdata = {29'h0, st.mask};
               `PHYSC_IDX_BSR, `PHYSC_IDX_AUTONEG_EXPANSION_REG, `PHYSC_IDX_ISR, `PHYSC_IDX_FCC:
                  next_st.rdata = 32'h0;
               default:         next_st.resp  = 2'h2;
            endcase
         end
      end

      // Clearing reads first, then events, so a set in the same cycle wins
      if (rd_acc && aligned && idx == `PHYSC_IDX_FCC)  next_st.fcs  = 1'b0;
      if (rd_acc && aligned && idx == `PHYSC_IDX_AUTONEG_EXPANSION_REG) next_st.pr   = 1'b0;
      if (rd_acc && aligned && idx == `PHYSC_IDX_ISR)  next_st.intp = 1'b0;
      if (rd_acc && aligned && idx == `PHYSC_IDX_BSR)  next_st.rf   = 1'b0;
      if (core.false_carrier)      next_st.fcs  = 1'b1;
      if (core.page_rx_event)      next_st.pr   = 1'b1;
      if (core.int_pending_event)  next_st.intp = 1'b1;
      if (core.remote_fault_event) next_st.rf   = 1'b1;

      // Latch-low: a read reloads the live level, otherwise only a loss moves it
      if (rd_sts) begin
         next_st.sd = sd_live;
         next_st.dl = dl_live;
      end
      if (!sd_live) next_st.sd = 1'b0;
      if (!dl_live) next_st.dl = 1'b0;

      // Control word writes; bits 10:0 lie outside this block and read zero
      if (wr_acc && aligned && idx == `PHYSC_IDX_CTL && avm_req.byteenable[1]) begin
         next_st.ctl_w = {avm_req.writedata[15:8], 8'h00} & `PHYSC_CTL_WMASK;
      end

      // Sleep sequencer; energy detect stays alive in both sleep modes.
      // Limitation: the pulse period restarts on every entry to sleep, so the
      // first pulse leaves one full period after the part falls asleep
      next_st.ctl_o.nlp_pulse = 1'b0;
      unique case (st.sleep_st)
         physc_st_awake: begin
            next_st.nlp_cnt = 32'h0;
            if (sleep_req && !core.energy_detect) next_st.sleep_st = physc_st_asleep;
         end
         physc_st_asleep: begin
            if (core.energy_detect || !sleep_req) begin
               next_st.sleep_st = physc_st_waking;
            end else if (mode == physc_mode_active) begin
               if (st.nlp_cnt >= 32'(NLP_CYCLES - 1)) begin
                  next_st.nlp_cnt         = 32'h0;
                  next_st.ctl_o.nlp_pulse = 1'b1;
                  ev_set[`PHYSC_EV_NLP]   = 1'b1;
               end else begin
                  next_st.nlp_cnt = st.nlp_cnt + 32'h1;
               end
            end else begin
               next_st.nlp_cnt = 32'h0;
            end
         end
         physc_st_waking: begin
            ev_set[`PHYSC_EV_WAKE] = core.energy_detect;
            // Clear power save enable, keep the mode, so the part stays awake until software re-arms it
            if (core.energy_detect) next_st.ctl_w[`PHYSC_CTL_PS_EN] = 1'b0;
            next_st.sleep_st = physc_st_awake;
         end
         default: next_st.sleep_st = physc_st_awake;
      endcase
      next_st.ctl_o.sleep = (next_st.sleep_st == physc_st_asleep);
      next_st.ctl_o.pll_disable = next_st.ctl_w[`PHYSC_CTL_PLL_OFF] & core.std_power_down;
      next_st.ctl_o.scr_bypass  = next_st.ctl_w[`PHYSC_CTL_SCR_BYP];
      ev_set[`PHYSC_EV_FCS] = core.false_carrier;

      // Interrupt status, write one to clear, set wins
      if (wr_acc && aligned && idx == `PHYSC_IDX_EVT && avm_req.byteenable[0]) begin
         next_st.evt = st.evt & ~avm_req.writedata[2:0];
      end
      next_st.evt = next_st.evt | ev_set;
      if (wr_acc && aligned && idx == `PHYSC_IDX_MASK && avm_req.byteenable[0]) begin
         next_st.mask = avm_req.writedata[2:0];
      end
      next_st.irq_o = |(next_st.evt & next_st.mask);
   end

   // State register
   always_ff @(posedge clk) begin
      if (reset) begin
         st          <= '0;
         st.ctl_w    <= `PHYSC_CTL_RESET;
         st.wait_req <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign avm_rsp.readdata    = st.rdata;
   assign avm_rsp.waitrequest = st.wait_req;
   assign avm_rsp.response    = st.resp;
   assign ctl                 = st.ctl_o;
   assign irq                 = st.irq_o;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   wire rd_fcc = rd_acc & aligned & (idx == `PHYSC_IDX_FCC);
   wire rd_isr = rd_acc & aligned & (idx == `PHYSC_IDX_ISR);
   wire rd_bsr = rd_acc & aligned & (idx == `PHYSC_IDX_BSR);
   wire rd_st  = rd_acc & aligned & (idx == `PHYSC_IDX_STS);
   wire rd_autoneg_expansion_reg = rd_acc & aligned & (idx == `PHYSC_IDX_AUTONEG_EXPANSION_REG);

   sequence s_ctl_write;
      wr_acc && aligned && idx == `PHYSC_IDX_CTL && avm_req.byteenable[1];
   endsequence

   // A false carrier followed by two cycles without a clearing read
   sequence s_fcs_kept;
      core.false_carrier ##1 !rd_fcc [*2];
   endsequence

   // Power save armed with a sleep mode while no energy is seen
   sequence s_sleep_armed;
      st.sleep_st == physc_st_awake && st.ctl_w[`PHYSC_CTL_PS_EN] &&
      (mode == physc_mode_active || mode == physc_mode_passive) && !core.energy_detect;
   endsequence

   a_fcs_latch_hold: assert property (@(posedge clk) disable iff (reset)
      s_fcs_kept |=> st.fcs)
      else $error("false carrier latch lost before clearing read");
   a_sd_latch_low: assert property (@(posedge clk) disable iff (reset)
      !sd_live && !rd_st |=> !st.sd)
      else $error("signal detect loss not held");
   a_dl_latch_low: assert property (@(posedge clk) disable iff (reset)
      !st.dl && !rd_st |=> !st.dl)
      else $error("descrambler lock loss not held");
   a_pr_clear_read: assert property (@(posedge clk) disable iff (reset)
      rd_acc && aligned && idx == `PHYSC_IDX_AUTONEG_EXPANSION_REG && !core.page_rx_event |=> !st.pr)
      else $error("page received not cleared by expansion read");
   a_int_clear_read: assert property (@(posedge clk) disable iff (reset)
      rd_isr && !core.int_pending_event |=> !st.intp)
      else $error("interrupt pending not cleared");
   a_rf_clear_read: assert property (@(posedge clk) disable iff (reset)
      rd_bsr && !core.remote_fault_event |=> !st.rf)
      else $error("remote fault not cleared");
   a_link_copy_read: assert property (@(posedge clk) disable iff (reset)
      rd_st |=> st.rdata[`PHYSC_ST_LNK] == $past(core.link_up) &&
                st.rdata[`PHYSC_ST_JAB] == $past(core.jabber))
      else $error("link or jabber copy wrong in status read");
   a_pll_gate_pd: assert property (@(posedge clk) disable iff (reset)
      ctl.pll_disable |-> $past(core.std_power_down))
      else $error("PLL disabled outside standard power down");
   a_ctl_write_take: assert property (@(posedge clk) disable iff (reset)
      s_ctl_write |=> ctl.scr_bypass == $past(avm_req.writedata[`PHYSC_CTL_SCR_BYP]))
      else $error("scrambler bypass not taken from write");
   a_sleep_needs_en: assert property (@(posedge clk) disable iff (reset)
      ctl.sleep |-> $past(st.ctl_w[`PHYSC_CTL_PS_EN]))
      else $error("sleep without power save enable");
   a_passive_no_nlp: assert property (@(posedge clk) disable iff (reset)
      st.sleep_st == physc_st_asleep && mode == physc_mode_passive |=> !ctl.nlp_pulse)
      else $error("pulse sent in passive sleep");
   a_mode_reset_val: assert property (@(posedge clk)
      $fell(reset) |-> mode == physc_mode_normal)
      else $error("mode field not normal after reset");
   a_wake_on_energy: assert property (@(posedge clk) disable iff (reset)
      st.sleep_st == physc_st_asleep && core.energy_detect |-> ##[1:2] !ctl.sleep)
      else $error("no wake on energy detect");
   a_fcs_clear_read: assert property (@(posedge clk) disable iff (reset)
      rd_fcc && !core.false_carrier |=> !st.fcs)
      else $error("false carrier not cleared by counter read");
   a_pr_latch_hold: assert property (@(posedge clk) disable iff (reset)
      st.pr && !rd_autoneg_expansion_reg |=> st.pr)
      else $error("page received lost before expansion read");
   a_int_latch_hold: assert property (@(posedge clk) disable iff (reset)
      st.intp && !rd_isr |=> st.intp)
      else $error("interrupt pending lost before its read");
   a_rf_latch_hold: assert property (@(posedge clk) disable iff (reset)
      st.rf && !rd_bsr |=> st.rf)
      else $error("remote fault lost before basic status read");
   a_sd_reload_read: assert property (@(posedge clk) disable iff (reset)
      rd_st && sd_live |=> st.sd)
      else $error("signal detect not reloaded by status read");
   a_dl_reload_read: assert property (@(posedge clk) disable iff (reset)
      rd_st && dl_live |=> st.dl)
      else $error("descrambler lock not reloaded by status read");
   a_an_lb_copy: assert property (@(posedge clk) disable iff (reset)
      rd_st |=> st.rdata[`PHYSC_ST_AN] == $past(core.an_done) &&
                st.rdata[`PHYSC_ST_LB] == $past(core.loopback))
      else $error("autoneg or loopback copy wrong in status read");
   a_speed_dup_copy: assert property (@(posedge clk) disable iff (reset)
      rd_st |=> st.rdata[`PHYSC_ST_SPD] == $past(core.speed_10) &&
                st.rdata[`PHYSC_ST_DUP] == $past(core.full_duplex))
      else $error("speed or duplex copy wrong in status read");
   a_pll_needs_bit: assert property (@(posedge clk) disable iff (reset)
      ctl.pll_disable |-> st.ctl_w[`PHYSC_CTL_PLL_OFF])
      else $error("PLL disabled without its control bit");
   a_nlp_only_active: assert property (@(posedge clk) disable iff (reset)
      ctl.nlp_pulse |-> $past(mode == physc_mode_active))
      else $error("link pulse outside active sleep");
   a_sleep_on_armed: assert property (@(posedge clk) disable iff (reset)
      s_sleep_armed |=> ctl.sleep)
      else $error("armed power save did not enter sleep");
   a_ctl_after_reset: assert property (@(posedge clk)
      $fell(reset) |-> !ctl.scr_bypass && !ctl.pll_disable)
      else $error("control outputs not idle after reset");

endmodule

// >>> verif/physc_core_model.sv
// Partner model: transceiver core and remote link partner beside the status block.
// Assumes the bench supplies live indications; energy detect on wake comes from here.
`timescale 1ns/1ps
module physc_core_model #(
   parameter int unsigned WAKE_CYCLES = 70
)(
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   reset,
   // Bench side
   input  wire physc_pkg::physc_core_s live,
   input  wire logic                   partner_on,
   output      int                     nlp_count,
   // Block side
   input  wire physc_pkg::physc_ctl_s  ctl,
   output      physc_pkg::physc_core_s core
);
   import physc_pkg::*;
   int unsigned asleep_cnt;
   // ------------------------------------------------------------
   // Sleep timing and pulse count
   // ------------------------------------------------------------
   // Partner only shows energy after a long sleep, so a wake is never instant
   always_ff @(posedge clk) begin
      if (reset || !ctl.sleep) begin
         asleep_cnt <= 0;
      end else if (asleep_cnt < WAKE_CYCLES) begin
         asleep_cnt <= asleep_cnt + 1;
      end
   end
   // Link pulses seen on the wire, restarted as each sleep begins
   always_ff @(posedge clk) begin
      if (reset || (ctl.sleep && asleep_cnt == 0)) begin
         nlp_count <= 0;
      end else if (ctl.nlp_pulse) begin
         nlp_count <= nlp_count + 1;
      end
   end
   // Energy appears once the partner is on and the block has slept; power down passes through
   always_comb begin
      core = live;
      core.energy_detect = live.energy_detect | (partner_on && asleep_cnt >= WAKE_CYCLES);
   end
endmodule

// >>> verif/phy_status_and_power_save_control_tb.sv
// Testbench: status word, control word, events, interrupt and sleep of the status block.
// Assumes the partner model in physc_core_model.sv and a short link pulse period of 20.
`timescale 1ns/1ps
module phy_status_and_power_save_control_tb;
   import physc_pkg::*;
   logic           clk   = 1'b0;
   logic           reset = 1'b1;
   logic           irq;
   logic           on    = 1'b0;
   logic [3:0]     lat   = 4'h0;
   logic           sdl   = 1'b0;
   logic           dll   = 1'b0;
   logic [31:0]    rd;
   logic [1:0]     rs;
   logic [31:0]    v;
   physc_avm_req_s req   = '0;
   physc_avm_rsp_s rsp;
   physc_core_s    live  = 14'h0008;
   physc_core_s    core;
   physc_ctl_s     ctl;
   int             nlp;
   int             fail_count = 0;
   int             cmp_count  = 0;
   int             cyc        = 0;
   int             seed       = 62862;
   int             eb[4] = '{13, 10, 9, 8};
   logic [7:0]     ca[4] = '{8'h50, 8'h18, 8'h48, 8'h04};
   logic [31:0]    cv[3] = '{32'h4000, 32'h5000, 32'h2000};

   physc_top #(.NLP_CYCLES(20)) physc_top_inst (.clk(clk), .reset(reset), .avm_req(req),
      .avm_rsp(rsp), .core(core), .ctl(ctl), .irq(irq));
   physc_core_model physc_core_model_inst (.clk(clk), .reset(reset), .live(live),
      .partner_on(on), .nlp_count(nlp), .ctl(ctl), .core(core));

   // ------------------------------------------------------------
   // Clock, timeout and shared tasks
   // ------------------------------------------------------------
   always #2.5 clk = ~clk;
   // A hang counts as a mismatch and still reaches the verdict
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         conclude();
      end
   end
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", nm, e, g);
         fail_count++;
      end
   endtask
   // One Avalon-MM access; holds everything until waitrequest is sampled low.
   // No cycle count is assumed: only the bench timeout ends a wait
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      req <= '{address: a, read: !w, write: w, writedata: d, byteenable: 4'hf};
      do begin
         @(posedge clk);
      end while (rsp.waitrequest !== 1'b0);
      rd = rsp.readdata;
      rs = rsp.response;
      req <= '0;
   endtask
   // Status read against the latch model; sd and dl reload after each read
   task automatic rd_sts();
      bus(1'b0, 8'h40, 32'h0);
      chk("status", {20'h0, lat[0], sdl, dll, lat[1], lat[2], lat[3], live[7:2]}, rd);
      sdl = live.signal_detect;
      dll = live.descr_lock;
   endtask
   task automatic pulse(input int b);
      @(posedge clk);
      live[b] <= 1'b1;
      @(posedge clk);
      live[b] <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task automatic wait_sleep(input logic want, input int lim);
      int n;
      n = 0;
      while (ctl.sleep !== want && n < lim) begin
         @(posedge clk);
         n++;
      end
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      rd_sts();
      bus(1'b0, 8'h44, 32'h0);
      chk("ctl reset", 32'h0, rd);
      $display("Test reset done");
      // Only bits 15..11 hold; bit 14 stays off so no sleep starts
      bus(1'b1, 8'h44, 32'hffffb800);
      bus(1'b0, 8'h44, 32'h0);
      chk("ctl readback", 32'hb800, rd);
      chk("scr bypass", 32'h1, ctl.scr_bypass);
      chk("pll no pd", 32'h0, ctl.pll_disable);
      live.std_power_down <= 1'b1;
      repeat (3) @(posedge clk);
      chk("pll pd", 32'h1, ctl.pll_disable);
      live.std_power_down <= 1'b0;
      bus(1'b1, 8'h44, 32'h0);
      chk("scr off", 32'h0, ctl.scr_bypass);
      bus(1'b0, 8'h08, 32'h0);
      chk("unmapped rsp", 32'h2, rs);
      chk("unmapped data", 32'h0, rd);
      bus(1'b0, 8'h41, 32'h0);
      chk("unaligned rsp", 32'h2, rs);
      $display("Test control done");
      // Signal detect and lock: not in low power idle here, so both bits count
      live.signal_detect <= 1'b1;
      live.descr_lock <= 1'b1;
      repeat (6) @(posedge clk);
      rd_sts();
      rd_sts();
      live.signal_detect <= 1'b0;
      live.descr_lock <= 1'b0;
      repeat (6) @(posedge clk);
      live.signal_detect <= 1'b1;
      live.descr_lock <= 1'b1;
      repeat (6) @(posedge clk);
      sdl = 1'b0;
      dll = 1'b0;
      rd_sts();
      rd_sts();
      $display("Test latch low done");
      // Each latch holds through status reads and clears only by its own read
      for (int i = 0; i < 4; i++) begin
         pulse(eb[i]);
         lat[i] = 1'b1;
         rd_sts();
         rd_sts();
         bus(1'b0, ca[i], 32'h0);
         chk("clear rsp", 32'h0, rs);
         lat[i] = 1'b0;
         rd_sts();
      end
      $display("Test latch high done");
      for (int i = 0; i < 6; i++) begin
         v = $random(seed);
         live[7:2] <= v[5:0];
         repeat (2) @(posedge clk);
         rd_sts();
         rd_sts();
      end
      $display("Test live bits done");
      bus(1'b1, 8'h80, 32'h7);
      bus(1'b1, 8'h84, 32'h4);
      pulse(13);
      chk("irq set", 32'h1, irq);
      bus(1'b1, 8'h84, 32'h0);
      repeat (2) @(posedge clk);
      chk("irq masked", 32'h0, irq);
      bus(1'b1, 8'h84, 32'h4);
      repeat (2) @(posedge clk);
      chk("irq unmasked", 32'h1, irq);
      bus(1'b1, 8'h80, 32'h4);
      repeat (2) @(posedge clk);
      chk("irq cleared", 32'h0, irq);
      bus(1'b0, 8'h80, 32'h0);
      chk("evt", 32'h0, rd);
      bus(1'b0, 8'h84, 32'h0);
      chk("mask", 32'h4, rd);
      bus(1'b0, 8'h50, 32'h0);
      $display("Test interrupt done");
      // Normal mode, reserved mode, or mode without enable must not sleep
      for (int i = 0; i < 3; i++) begin
         bus(1'b1, 8'h44, cv[i]);
         repeat (30) @(posedge clk);
         chk("no sleep", 32'h0, ctl.sleep);
      end
      for (int m = 2; m < 4; m++) begin
         bus(1'b1, 8'h44, 32'h4000 | (m << 12));
         wait_sleep(1'b1, 20);
         chk("sleep", 32'h1, ctl.sleep);
         on <= 1'b1;
         wait_sleep(1'b0, 200);
         on <= 1'b0;
         chk("woken", 32'h0, ctl.sleep);
         chk("pulses", 32'h1, (m == 2) ? (nlp >= 3 && nlp <= 4) : (nlp == 0));
         bus(1'b0, 8'h44, 32'h0);
         chk("ctl after wake", m << 12, rd);
         bus(1'b0, 8'h80, 32'h0);
         chk("wake evt", (m == 2) ? 32'h3 : 32'h1, rd);
         bus(1'b1, 8'h80, 32'h3);
      end
      $display("Test sleep done");
      conclude();
   end
endmodule
